// >>> design/nvma_defs.vh
`ifndef NVMA_DEFS_VH
`define NVMA_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets, one aligned 32-bit word each
`define NVMA_OFS_CTRL      5'h00  // nvm_control_one
`define NVMA_OFS_UNLOCK    5'h04  // nvm_unlock_pattern
`define NVMA_OFS_ADRL      5'h08  // eeprom_address_low
`define NVMA_OFS_ADRH      5'h0c  // eeprom_address_high, absent
`define NVMA_OFS_DATA      5'h10  // eeprom_data
`define NVMA_OFS_IRQ_REQ   5'h14  // interrupt_request_reg_seven
`define NVMA_OFS_IRQ_EN    5'h18  // interrupt_enable_reg_seven
`define NVMA_OFS_IRQ_PRI   5'h1c  // interrupt_priority_reg_seven

////////////////////////////////////////////////////////////////////////////
// Field positions in nvm_control_one
`define NVMA_BIT_RD        0
`define NVMA_BIT_WR        1
`define NVMA_BIT_WRITE_ENABLE_BIT      2
`define NVMA_BIT_WRITE_ERROR_FLAG     3
`define NVMA_BIT_FREE      4
`define NVMA_BIT_REG_LO    6
`define NVMA_BIT_REG_HI    7
// Done flag, enable and priority position in the interrupt registers
`define NVMA_BIT_DONE      5

////////////////////////////////////////////////////////////////////////////
// Region select codes
`define NVMA_REGION_EE     2'b00
`define NVMA_REGION_PFM    2'b10

////////////////////////////////////////////////////////////////////////////
// Unlock keys and unlock detector states
`define NVMA_KEY_FIRST     8'h55
`define NVMA_KEY_SECOND    8'haa
`define NVMA_UNL_IDLE      2'h0
`define NVMA_UNL_HALF      2'h1
`define NVMA_UNL_ARMED     2'h2

////////////////////////////////////////////////////////////////////////////
// Timing
`define NVMA_CLK_PERIOD_NS 4
`define NVMA_PROG_TIME_NS  4000000
`define NVMA_TMR_W         24
`define NVMA_TMR_ONE       24'h000001
`define NVMA_TMR_ZERO      24'h000000

////////////////////////////////////////////////////////////////////////////
// Widths and zero values
`define NVMA_BYTE_ZERO     8'h00
`define NVMA_WORD_ZERO     32'h00000000
`define NVMA_PAD_ZERO      24'h000000

`endif

// >>> design/nvma_unlock.v
`timescale 1ns/10ps
`include "nvma_defs.vh"

// Watches the unlock pattern register for the two keys in a row
module nvma_unlock (
    input  wire       i_clk,        // System clock
    input  wire       i_rst,        // Synchronous reset, high
    input  wire       i_key_wr,     // Write to the unlock register
    input  wire [7:0] i_key_data,   // Byte written there
    input  wire       i_other_wr,   // Write to any other register
    output wire       o_armed       // Keys seen, next write may start
);

    reg [1:0] state_ff;     // Detector state
    reg [1:0] nxt_state;    // Next state

    ////////////////////////////////////////////////////////////////////////
    // Any other write breaks or consumes the sequence, so one unlock
    // admits at most one write start
    always @* begin
        nxt_state = state_ff;
        if (i_other_wr) begin
            nxt_state = `NVMA_UNL_IDLE;
        end else if (i_key_wr) begin
            case (state_ff)
                `NVMA_UNL_HALF: begin
                    if (i_key_data == `NVMA_KEY_SECOND) begin
                        nxt_state = `NVMA_UNL_ARMED;
                    end else if (i_key_data == `NVMA_KEY_FIRST) begin
                        nxt_state = `NVMA_UNL_HALF;
                    end else begin
                        nxt_state = `NVMA_UNL_IDLE;
                    end
                end
                default: begin
                    // Restart on the first key, else drop
                    if (i_key_data == `NVMA_KEY_FIRST) begin
                        nxt_state = `NVMA_UNL_HALF;
                    end else begin
                        nxt_state = `NVMA_UNL_IDLE;
                    end
                end
            endcase
        end
    end

    // State register
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= `NVMA_UNL_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_armed = (state_ff == `NVMA_UNL_ARMED);

endmodule // nvma_unlock

// >>> design/nvma_prog_timer.v
`timescale 1ns/10ps
`include "nvma_defs.vh"

// Self-timed program/erase duration counter
module nvma_prog_timer #(
    parameter [`NVMA_TMR_W-1:0] PROG_CYCLES = `NVMA_TMR_ONE
) (
    input  wire i_clk,      // System clock
    input  wire i_rst,      // Synchronous reset, aborts the count
    input  wire i_start,    // Start pulse
    output wire o_done      // One-cycle pulse at the end
);

    reg [`NVMA_TMR_W-1:0] cnt_ff;   // Cycles left, zero when idle

    ////////////////////////////////////////////////////////////////////////
    // Load on start, count down to zero
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_ff <= `NVMA_TMR_ZERO;
        end else if (i_start) begin
            cnt_ff <= PROG_CYCLES;
        end else if (cnt_ff != `NVMA_TMR_ZERO) begin
            cnt_ff <= cnt_ff - `NVMA_TMR_ONE;
        end
    end

    assign o_done = (cnt_ff == `NVMA_TMR_ONE);

endmodule // nvma_prog_timer

// >>> design/nvma_top.v
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "nvma_defs.vh"

// Behaviour
// - Region field selects flash, ID space, EEPROM
// - Erase bit turns next flash start into erase
// - Error flag on reset-abort or bad start
// - Only software clears error flag; may set
// - Write-enable low blocks all program and erase
// - Write start launches EEPROM or flash write
// - Write start needs a fresh unlock sequence
// - Hardware clears write start when timed done
// - Clearing write start mid-write does nothing
// - Read start loads addressed byte into data
// - Read start set by software, hardware cleared
// - Unlock register always reads zero
// - Only eight-bit low address exists here
// - Data register holds read or write byte
// - Done flag, enable, priority at bit five
// - Write-enable must already be set first
// - Write end clears start, sets done flag
// - Read data valid on next instruction cycle
module nvma_top #(
    parameter PROG_TIME_NS = `NVMA_PROG_TIME_NS  // Program duration
) (
    input  wire        I_CLK_SYS,           // 250 MHz system clock
    input  wire        I_RESET,             // Sync reset, high
    input  wire        I_POR,               // Sync power-on reset, high
    // Avalon-MM slave
    input  wire [4:0]  I_AVS_ADDRESS,       // Byte address
    input  wire        I_AVS_READ,          // Read request
    input  wire        I_AVS_WRITE,         // Write request
    input  wire [3:0]  I_AVS_BYTEENABLE,    // Byte lanes
    input  wire [31:0] I_AVS_WRITEDATA,     // Write data
    output wire [31:0] O_AVS_READDATA,      // Read data
    output wire        O_AVS_WAITREQUEST,   // Stall
    // Memory array side
    input  wire [7:0]  I_MEM_RDATA,         // Array read byte
    input  wire        I_WRITE_PROTECT,     // Target is protected
    input  wire        I_ADDR_INVALID,      // Address bad for region
    output wire [1:0]  O_MEM_REGION,        // Selected region
    output wire [7:0]  O_MEM_ADDR,          // Array address
    output wire [7:0]  O_MEM_WDATA,         // Byte to program
    output wire        O_MEM_RD,            // Read strobe
    output wire        O_MEM_WR,            // Write launch pulse
    output wire        O_MEM_ERASE,         // Launch is an erase
    output wire        O_MEM_WRITE_ACTIVE,  // Timed write running
    // Interrupt controller side
    output wire        O_NVM_DONE_FLAG,     // Write complete flag
    output wire        O_NVM_DONE_ENABLE,   // Its enable
    output wire        O_NVM_DONE_PRIORITY  // Its priority
);

    ////////////////////////////////////////////////////////////////////////
    // Timing constants; least time rounds up to whole cycles
    localparam integer PROG_CYC_INT =
        (PROG_TIME_NS + `NVMA_CLK_PERIOD_NS - 1) / `NVMA_CLK_PERIOD_NS;
    localparam [`NVMA_TMR_W-1:0] PROG_CYCLES =
        (PROG_CYC_INT < 1) ? `NVMA_TMR_ONE : PROG_CYC_INT[`NVMA_TMR_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Address decode, used for reads and writes alike
    function hit;
        input [4:0] addr;   // Bus address
        input [4:0] ofs;    // Register offset
        begin
            hit = (addr == ofs);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    wire       rst_any;          // Either reset
    wire       req;              // Bus request present
    reg        ack_ff;           // Second cycle of an access
    wire       wr_acc;           // Write takes effect now
    wire       rd_smp;           // Read data sampled now
    reg [31:0] rdata_ff;         // Registered read data
    reg [31:0] nxt_rdata;        // Read mux

    reg [1:0]  region_ff;        // region_select
    reg        free_ff;          // Erase select
    reg        write_error_flag_ff;         // write_error_flag
    reg        write_enable_bit_ff;          // write_enable_bit
    reg        wr_ff;            // Write start / busy
    reg        rd_ff;            // Read start
    reg [7:0]  adrl_ff;          // eeprom_address_low
    reg [7:0]  data_ff;          // eeprom_data
    reg        done_flag_ff;     // nvm_done_flag
    reg        done_en_ff;       // nvm_done_enable
    reg        done_pri_ff;      // nvm_done_priority
    reg        launch_ff;        // Write launch pulse
    reg        erase_ff;         // Launched op is an erase

    wire       ctl_wr;           // Accepted write to control
    wire       key_wr;           // Write to unlock register
    wire       other_wr;         // Write elsewhere
    wire       armed;            // Unlock sequence complete
    wire       wr_try;           // Start attempt that is allowed
    wire       wr_bad;           // Start attempt on bad target
    wire       wr_go;            // Start the timed write
    wire       rd_go;            // Start a read
    wire       tmr_done;         // Timed write finished
    wire       locked;           // Write running, regs frozen

    assign rst_any = I_RESET | I_POR;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle on every access. Read data is
    // latched in the first cycle and stands at the release edge.
    assign req               = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req & ~ack_ff;
    assign wr_acc            = I_AVS_WRITE & ack_ff & I_AVS_BYTEENABLE[0];
    assign rd_smp            = I_AVS_READ & ~ack_ff;

    // Ack toggles so back-to-back requests each get their wait cycle
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write strobes per register
    assign locked   = wr_ff;
    assign key_wr   = wr_acc & hit(I_AVS_ADDRESS, `NVMA_OFS_UNLOCK);
    assign other_wr = wr_acc & ~hit(I_AVS_ADDRESS, `NVMA_OFS_UNLOCK);
    // Control frozen while a write runs, so a zero to WR is lost
    assign ctl_wr   = wr_acc & hit(I_AVS_ADDRESS, `NVMA_OFS_CTRL) & ~locked;

    ////////////////////////////////////////////////////////////////////////
    // Unlock detector; the control write itself consumes the arming
    nvma_unlock u_unlock (
        .i_clk      (I_CLK_SYS),
        .i_rst      (rst_any),
        .i_key_wr   (key_wr),
        .i_key_data (I_AVS_WRITEDATA[7:0]),
        .i_other_wr (other_wr),
        .o_armed    (armed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write start qualification. Old write-enable is used, so one write
    // cannot set both bits at once.
    assign wr_try = ctl_wr & I_AVS_WRITEDATA[`NVMA_BIT_WR]
                  & armed
                  & write_enable_bit_ff;
    assign wr_bad = wr_try & (I_WRITE_PROTECT | I_ADDR_INVALID);
    assign wr_go  = wr_try & ~wr_bad;

    // Read start refused for flash, which is read by table reads
    assign rd_go = ctl_wr & I_AVS_WRITEDATA[`NVMA_BIT_RD]
                 & (I_AVS_WRITEDATA[`NVMA_BIT_REG_HI:`NVMA_BIT_REG_LO]
                    != `NVMA_REGION_PFM)
                 & ~wr_go;

    ////////////////////////////////////////////////////////////////////////
    // Self-timed duration
    nvma_prog_timer #(
        .PROG_CYCLES (PROG_CYCLES)
    ) u_timer (
        .i_clk   (I_CLK_SYS),
        .i_rst   (rst_any),
        .i_start (wr_go),
        .o_done  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register region, erase select and write-enable fields
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            region_ff <= `NVMA_REGION_EE;
            free_ff   <= 1'b0;
            write_enable_bit_ff   <= 1'b0;
        end else if (ctl_wr) begin
            // Region steers reads and writes
            region_ff <= I_AVS_WRITEDATA[`NVMA_BIT_REG_HI:`NVMA_BIT_REG_LO];
            free_ff   <= I_AVS_WRITEDATA[`NVMA_BIT_FREE];
            write_enable_bit_ff   <= I_AVS_WRITEDATA[`NVMA_BIT_WRITE_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error flag: no hardware clear anywhere. Warm reset sets it when a
    // write was cut short; only power-on gives it a defined zero.
    always @(posedge I_CLK_SYS) begin
        if (I_POR) begin
            write_error_flag_ff <= 1'b0;
        end else if (I_RESET) begin
            write_error_flag_ff <= write_error_flag_ff | wr_ff;
        end else if (wr_bad) begin
            write_error_flag_ff <= 1'b1;
        end else if (ctl_wr) begin
            // Software may clear, or set for test
            write_error_flag_ff <= I_AVS_WRITEDATA[`NVMA_BIT_WRITE_ERROR_FLAG];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write start bit: set only through wr_go, cleared by the timer
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            wr_ff     <= 1'b0;
            launch_ff <= 1'b0;
            erase_ff  <= 1'b0;
        end else begin
            launch_ff <= wr_go;
            if (wr_go) begin
                wr_ff    <= 1'b1;
                // Erase applies to flash only; EEPROM erases implicitly.
                // Fields of this same write, as the region port shows them
                erase_ff <= I_AVS_WRITEDATA[`NVMA_BIT_FREE]
                          & (I_AVS_WRITEDATA[`NVMA_BIT_REG_HI:`NVMA_BIT_REG_LO]
                             == `NVMA_REGION_PFM);
            end else if (tmr_done) begin
                wr_ff    <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read start: one cycle high, data captured at the edge that clears it
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            rd_ff <= 1'b0;
        end else if (rd_ff) begin
            rd_ff <= 1'b0;
        end else if (rd_go) begin
            rd_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address low byte; the high byte does not exist here
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            adrl_ff <= `NVMA_BYTE_ZERO;
        end else if (wr_acc & ~locked
                     & hit(I_AVS_ADDRESS, `NVMA_OFS_ADRL)) begin
            adrl_ff <= I_AVS_WRITEDATA[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data byte: array read wins over a software write
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            data_ff <= `NVMA_BYTE_ZERO;
        end else if (rd_ff) begin
            data_ff <= I_MEM_RDATA;
        end else if (wr_acc & ~locked
                     & hit(I_AVS_ADDRESS, `NVMA_OFS_DATA)) begin
            data_ff <= I_AVS_WRITEDATA[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion flag, enable and priority; the set beats a clear
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            done_flag_ff <= 1'b0;
            done_en_ff   <= 1'b0;
            done_pri_ff  <= 1'b0;
        end else begin
            if (tmr_done) begin
                done_flag_ff <= 1'b1;
            end else if (wr_acc & hit(I_AVS_ADDRESS, `NVMA_OFS_IRQ_REQ)) begin
                done_flag_ff <= I_AVS_WRITEDATA[`NVMA_BIT_DONE];
            end
            if (wr_acc & hit(I_AVS_ADDRESS, `NVMA_OFS_IRQ_EN)) begin
                done_en_ff <= I_AVS_WRITEDATA[`NVMA_BIT_DONE];
            end
            if (wr_acc & hit(I_AVS_ADDRESS, `NVMA_OFS_IRQ_PRI)) begin
                done_pri_ff <= I_AVS_WRITEDATA[`NVMA_BIT_DONE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped, unlock and high address read as zero
    always @* begin
        nxt_rdata = `NVMA_WORD_ZERO;
        if (hit(I_AVS_ADDRESS, `NVMA_OFS_CTRL)) begin
            nxt_rdata = {`NVMA_PAD_ZERO, region_ff, 1'b0, free_ff,
                         write_error_flag_ff, write_enable_bit_ff, wr_ff, rd_ff};
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_UNLOCK)) begin
            nxt_rdata = `NVMA_WORD_ZERO;
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_ADRL)) begin
            nxt_rdata = {`NVMA_PAD_ZERO, adrl_ff};
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_ADRH)) begin
            nxt_rdata = `NVMA_WORD_ZERO;
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_DATA)) begin
            nxt_rdata = {`NVMA_PAD_ZERO, data_ff};
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_IRQ_REQ)) begin
            nxt_rdata = {`NVMA_PAD_ZERO, 2'b00, done_flag_ff, 5'b00000};
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_IRQ_EN)) begin
            nxt_rdata = {`NVMA_PAD_ZERO, 2'b00, done_en_ff, 5'b00000};
        end else if (hit(I_AVS_ADDRESS, `NVMA_OFS_IRQ_PRI)) begin
            nxt_rdata = {`NVMA_PAD_ZERO, 2'b00, done_pri_ff, 5'b00000};
        end
    end

    // Read data latched in the wait cycle
    always @(posedge I_CLK_SYS) begin
        if (rst_any) begin
            rdata_ff <= `NVMA_WORD_ZERO;
        end else if (rd_smp) begin
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign O_AVS_READDATA      = rdata_ff;
    assign O_MEM_REGION        = region_ff;
    assign O_MEM_ADDR          = adrl_ff;
    assign O_MEM_WDATA         = data_ff;
    assign O_MEM_RD            = rd_ff;
    assign O_MEM_WR            = launch_ff;
    assign O_MEM_ERASE         = erase_ff;
    assign O_MEM_WRITE_ACTIVE  = wr_ff;
    assign O_NVM_DONE_FLAG     = done_flag_ff;
    assign O_NVM_DONE_ENABLE   = done_en_ff;
    assign O_NVM_DONE_PRIORITY = done_pri_ff;

endmodule // nvma_top

// >>> tb/nvma_asserts.sv
`timescale 1ns/10ps
module nvma_asserts #(
    parameter PROG_TIME_NS = 200
) (
    input wire        I_CLK_SYS,
    input wire        I_RESET,
    input wire        I_POR,
    input wire [4:0]  I_AVS_ADDRESS,
    input wire        I_AVS_READ,
    input wire        I_AVS_WRITE,
    input wire [31:0] O_AVS_READDATA,
    input wire        O_AVS_WAITREQUEST,
    input wire [7:0]  I_MEM_RDATA,
    input wire [1:0]  O_MEM_REGION,
    input wire [7:0]  O_MEM_ADDR,
    input wire [7:0]  O_MEM_WDATA,
    input wire        O_MEM_RD,
    input wire        O_MEM_WR,
    input wire        O_MEM_ERASE,
    input wire        O_MEM_WRITE_ACTIVE,
    input wire        O_NVM_DONE_FLAG
);
    // Cycles the write stays active after the rise, minus the last one
    localparam int CYC_M1 = (PROG_TIME_NS + 3) / 4 - 1;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET || I_POR);
    // Launch pulse rises with the start bit and lasts one cycle
    sequence s_launch;
        O_MEM_WR ##1 !O_MEM_WR;
    endsequence
    // Timed run, then the start bit drops
    sequence s_timed;
        ##CYC_M1 O_MEM_WRITE_ACTIVE ##1 !O_MEM_WRITE_ACTIVE;
    endsequence
    chk_unlock_reads_zero: assert property (
        I_AVS_READ && I_AVS_ADDRESS == 5'h04 && !O_AVS_WAITREQUEST
        |-> O_AVS_READDATA == 32'h00000000) else $error("unlock not zero");
    chk_write_launch: assert property (
        $rose(O_MEM_WRITE_ACTIVE) |-> s_launch) else $error("no launch");
    chk_write_duration: assert property (
        $rose(O_MEM_WRITE_ACTIVE) |-> s_timed) else $error("bad duration");
    chk_done_on_end: assert property (
        $fell(O_MEM_WRITE_ACTIVE) && !$past(I_RESET || I_POR)
        |-> O_NVM_DONE_FLAG) else $error("done flag not set");
    chk_busy_regs_held: assert property (
        O_MEM_WRITE_ACTIVE && $past(O_MEM_WRITE_ACTIVE)
        |-> $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA))
        else $error("regs changed while busy");
    chk_read_capture: assert property (
        O_MEM_RD |=> !O_MEM_RD && O_MEM_WDATA == $past(I_MEM_RDATA))
        else $error("read not captured");
    chk_no_flash_read: assert property (
        O_MEM_RD |-> O_MEM_REGION != 2'b10) else $error("flash read");
    chk_erase_flash_only: assert property (
        O_MEM_WR && O_MEM_ERASE |-> O_MEM_REGION == 2'b10)
        else $error("erase outside flash");
    chk_done_sw_clear: assert property (
        $fell(O_NVM_DONE_FLAG) && !$past(I_RESET || I_POR)
        |-> $past(I_AVS_WRITE && I_AVS_ADDRESS == 5'h14
        && !O_AVS_WAITREQUEST)) else $error("done flag hw cleared");
endmodule // nvma_asserts
bind nvma_top nvma_asserts #(.PROG_TIME_NS(PROG_TIME_NS)) i_chk (.*);

// >>> tb/nvma_mem_model.sv
`timescale 1ns/10ps
// Array stand-in: one byte space, fixed bad and protected addresses
module nvma_mem_model #(
    parameter [7:0] PROT_ADDR = 8'hf0,
    parameter [7:0] BAD_ADDR  = 8'hee
) (
    input  wire       i_clk,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_rd,
    input  wire       i_wr,
    input  wire       i_erase,
    output wire [7:0] o_rdata,
    output wire       o_protect,
    output wire       o_invalid
);
    logic [7:0] mem [0:255];  // Seeded with a known pattern
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
    // Erase leaves all ones, else erase then program the byte
    always @(posedge i_clk) if (i_wr) mem[i_addr] <= i_erase ? 8'hff
        : i_wdata;
    // Outside a strobe the bus shows garbage, never the old byte
    assign o_rdata   = i_rd ? mem[i_addr] : ~mem[i_addr];
    assign o_protect = (i_addr == PROT_ADDR);
    assign o_invalid = (i_addr == BAD_ADDR);
endmodule // nvma_mem_model

// >>> tb/nvma_top_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module nvma_top_tb_top;
    localparam PT = 200;  // 50 cycles, room for accesses mid-write
    logic clk = 0, rst = 1, por = 1, rd = 0, wr = 0;
    logic [4:0] adr = 0;
    logic [3:0] be = 4'h1;
    logic [31:0] wd = 0, q;
    wire [31:0] rdat;
    wire [7:0] ma, mwd, mrdat;
    wire [1:0] rg;
    wire wq, mrd, mwr, mer, act, dfl, den, dpr, prot, inv;
    int bad_count = 0, n_checks = 0;
    logic [4:0] ta [9] = '{0, 4, 8, 'h0c, 'h10, 'h14, 'h18, 'h1c, 2};
    logic [7:0] td [9] = '{'hfc, 'h55, 'ha5, 'hff, 'h3c, 'hff, 'hff, 'hff, 1};
    logic [7:0] te [9] = '{'hdc, 0, 'ha5, 0, 'h3c, 'h20, 'h20, 'h20, 0};
    always #2 clk = ~clk;
    nvma_top #(.PROG_TIME_NS(PT)) i_dut (.I_CLK_SYS(clk), .I_RESET(rst),
        .I_POR(por), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_BYTEENABLE(be), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wq), .I_MEM_RDATA(mrdat), .I_WRITE_PROTECT(prot),
        .I_ADDR_INVALID(inv), .O_MEM_REGION(rg), .O_MEM_ADDR(ma),
        .O_MEM_WDATA(mwd), .O_MEM_RD(mrd), .O_MEM_WR(mwr), .O_MEM_ERASE(mer),
        .O_MEM_WRITE_ACTIVE(act), .O_NVM_DONE_FLAG(dfl),
        .O_NVM_DONE_ENABLE(den), .O_NVM_DONE_PRIORITY(dpr));
    nvma_mem_model i_mem (.i_clk(clk), .i_addr(ma), .i_wdata(mwd),
        .i_rd(mrd), .i_wr(mwr), .i_erase(mer), .o_rdata(mrdat),
        .o_protect(prot), .o_invalid(inv));
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One Avalon access; answer sampled on the edge waitrequest is low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        int n;
        logic ok;
        @(posedge clk);
        wr <= w; rd <= !w; adr <= a; wd <= {24'h000000, d};
        n = 0; ok = 0;
        while (!ok) begin
            // Design registers update by NBA, so these are still the
            // values that stood up to this rising edge
            @(posedge clk); ok = (wq === 1'b0); q = rdat;
            n++;
            if (n > 20) begin bad_count++; results(); end
        end
        wr <= 1'b0; rd <= 1'b0;
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK("readdata", {24'h000000, e}, q)
    endtask
    task automatic unl;  // Two keys in a row
        bus(1'b1, 5'h04, 8'h55); bus(1'b1, 5'h04, 8'haa);
    endtask
    // Bounded wait for the timed write to finish
    task automatic idle;
        int n;
        n = 0;
        while (act !== 1'b0) begin
            @(negedge clk); n++;
            if (n > 200) begin bad_count++; results(); end
        end
    endtask
    task automatic launch(input logic [7:0] c, input logic e);
        unl; bus(1'b1, 5'h00, c); @(negedge clk);
        `CHK("erase", e, mer)
        idle;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0; por <= 1'b0;
        for (int a = 0; a < 32; a += 4) rc(a[4:0], 8'h00);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin  // Plain write, read back
            bus(1'b1, ta[i], td[i]); rc(ta[i], te[i]);
        end
        `CHK("ports", 13'h1d2f, {rg, ma, dfl, den, dpr})
        be <= 4'h0; bus(1'b1, 5'h08, 8'h00); be <= 4'h1; rc(5'h08, 8'ha5);
        bus(1'b1, 5'h14, 8'h00); $display("test rows done");
        bus(1'b1, 5'h08, 8'h21); bus(1'b1, 5'h00, 8'h01); rc(0, 8'h00);
        rc(5'h10, 8'h7b);
        bus(1'b1, 5'h00, 8'h81); rc(5'h10, 8'h7b); rc(0, 8'h80);
        bus(1'b1, 5'h00, 8'h04); bus(1'b1, 5'h00, 8'h06); rc(0, 8'h04);
        bus(1'b1, 5'h00, 8'h00); unl; bus(1'b1, 0, 8'h06); rc(0, 8'h04);
        bus(1'b1, 5'h04, 8'h55); bus(1'b1, 5'h08, 8'h30);
        bus(1'b1, 5'h04, 8'haa); bus(1'b1, 0, 8'h06); rc(0, 8'h04);
        $display("test refusals done");
        bus(1'b1, 5'h10, 8'h77); unl; bus(1'b1, 0, 8'h06); rc(0, 8'h06);
        bus(1'b1, 0, 8'h04); bus(1'b1, 5'h10, 8'h11); bus(1'b1, 8, 8'h31);
        rc(0, 8'h06); rc(5'h10, 8'h77); rc(5'h08, 8'h30);
        idle; `CHK("done", 1'b1, dfl)
        rc(0, 8'h04); bus(1'b1, 5'h10, 8'h00);
        bus(1'b1, 0, 8'h05); rc(5'h10, 8'h77);
        bus(1'b1, 5'h14, 8'h00); @(negedge clk);
        `CHK("done", 1'b0, dfl)
        launch(8'h96, 1'b1); launch(8'h16, 1'b0);
        $display("test writes done");
        for (int k = 0; k < 2; k++) begin  // Protected, then bad address
            bus(1'b1, 5'h08, k ? 8'hee : 8'hf0); bus(1'b1, 0, 8'h04); unl;
            bus(1'b1, 0, 8'h06); rc(0, 8'h0c);
            bus(1'b1, 0, 8'h04); rc(0, 8'h04);
        end
        bus(1'b1, 0, 8'h0c); rc(0, 8'h0c); bus(1'b1, 0, 8'h04);
        bus(1'b1, 8, 8'h40); unl; bus(1'b1, 0, 8'h06);
        @(posedge clk); rst <= 1'b1; @(posedge clk); rst <= 1'b0;
        rc(0, 8'h08); `CHK("active", 1'b0, act)
        $display("test errors done");
        results();
    end
endmodule // nvma_top_tb_top
